// >>> rbs_pkg.sv
// Constants, register map and types of the return and bit-set unit
// Assumes an AXI4-Lite master with 32-bit data and one 125 MHz clock
// Functional notes
// - Interrupt return pops PC, then decrements SP
// - Interrupt return restores saved pointer, flags, A, B
// - Return-skip pops PC, decrements SP, skips next
// - Flag clear op; clear flag blocks table high bits
// - Bit-set op sets bit j of addressed word
`default_nettype none
package rbs_pkg;
   // Bus geometry and answers
   localparam int          AXI_AW       = 8;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   // Register byte offsets
   localparam logic [7:0]  REG_INSTR    = 8'h00;
   localparam logic [7:0]  REG_STATUS   = 8'h04;
   localparam logic [7:0]  REG_PC       = 8'h08;
   localparam logic [7:0]  REG_PTR      = 8'h0c;
   localparam logic [7:0]  REG_ACC      = 8'h10;
   localparam logic [7:0]  REG_SAVE     = 8'h14;
   localparam logic [7:0]  REG_PUSH     = 8'h18;
   localparam logic [7:0]  REG_RAMADDR  = 8'h1c;
   localparam logic [7:0]  REG_RAMDATA  = 8'h20;
   localparam logic [7:0]  REG_TABLE    = 8'h24;
   localparam logic [7:0]  REG_CTRL     = 8'h28;
   // Instruction codes
   localparam logic [9:0]  OP_INTERRUPT_RETURN  = 10'h046;
   localparam logic [9:0]  OP_RETURN_SKIP       = 10'h045;
   localparam logic [9:0]  OP_TABLE_HIGH_CLEAR  = 10'h058;
   localparam logic [9:0]  OP_BIT_SET_BASE      = 10'h05c;
   localparam logic [9:0]  OP_BIT_SET_MASK      = 10'h3fc;
   // Storage sizes
   localparam int          PC_W         = 14;
   localparam int          SP_W         = 3;
   localparam int          STACK_DEPTH  = 8;
   localparam int          RAM_WORDS    = 128;
   localparam logic [2:0]  SP_ONE       = 3'h1;
   // Reset values
   localparam logic [13:0] PC_RST       = 14'h0000;
   localparam logic [2:0]  SP_RST       = 3'h7;
   localparam logic        FLAG_RST     = 1'b0;
   // Field positions: pointer, accumulators, saved context
   localparam int          PTR_Y_LSB    = 0;
   localparam int          PTR_X_LSB    = 4;
   localparam int          PTR_Z_LSB    = 8;
   localparam int          ACC_A_LSB    = 0;
   localparam int          ACC_B_LSB    = 4;
   localparam int          ACC_CY_BIT   = 8;
   localparam int          ACC_NOP_BIT  = 9;
   localparam int          SV_CY_BIT    = 12;
   localparam int          SV_SKIP_BIT  = 13;
   localparam int          SV_NOP_BIT   = 14;
   localparam int          SV_A_LSB     = 16;
   localparam int          SV_B_LSB     = 20;
   // Field positions: status, table data, control
   localparam int          ST_BUSY_BIT  = 0;
   localparam int          ST_SKIP_BIT  = 1;
   localparam int          ST_FLAG_BIT  = 2;
   localparam int          ST_SP_LSB    = 8;
   localparam int          ST_HI_LSB    = 12;
   localparam int          TAB_HI_LSB   = 8;
   localparam int          CTRL_SET_BIT = 0;
   // Execution states
   typedef enum logic {RBS_IDLE, RBS_POP} rbs_state_t;
endpackage
`default_nettype wire

// >>> rbs_exec_unit.sv
// Return and bit-set execution unit with its AXI4-Lite register slave
// Assumes one clock, synchronous reset and a master that holds valid
`timescale 1ns/100ps
`default_nettype none
module rbs_exec_unit (
   // Clock and reset
   input  wire logic                       mclk,
   input  wire logic                       rst,
   // Write address channel
   input  wire logic [rbs_pkg::AXI_AW-1:0] s_axi_awaddr,
   input  wire logic [2:0]                 s_axi_awprot,
   input  wire logic                       s_axi_awvalid,
   output var  logic                       s_axi_awready,
   // Write data channel
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output var  logic                       s_axi_wready,
   // Write response channel
   output var  logic [1:0]                 s_axi_bresp,
   output var  logic                       s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   // Read address channel
   input  wire logic [rbs_pkg::AXI_AW-1:0] s_axi_araddr,
   input  wire logic [2:0]                 s_axi_arprot,
   input  wire logic                       s_axi_arvalid,
   output var  logic                       s_axi_arready,
   // Read data channel
   output var  logic [31:0]                s_axi_rdata,
   output var  logic [1:0]                 s_axi_rresp,
   output var  logic                       s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   // Execution status
   output var  logic                       busy_reg,
   output var  logic [1:0]                 table_high_reg
);
   import rbs_pkg::*;

   // Core state
   rbs_state_t       state_reg;
   logic             pop_iret_reg;
   logic [PC_W-1:0]  pc_reg;
   logic [SP_W-1:0]  sp_reg;
   logic [PC_W-1:0]  call_stack [STACK_DEPTH];
   logic [3:0]       ram [RAM_WORDS];
   logic [6:0]       ram_addr_reg;
   logic [9:0]       instr_reg;
   logic             table_high_bits_enable_flag_reg;
   // Live context
   logic [3:0]       x_reg;
   logic [3:0]       y_reg;
   logic [1:0]       z_reg;
   logic [3:0]       a_reg;
   logic [3:0]       b_reg;
   logic             carry_reg;
   logic             skip_reg;
   logic             nop_reg;
   // Context saved at interrupt entry
   logic [3:0]       sv_x_reg;
   logic [3:0]       sv_y_reg;
   logic [1:0]       sv_z_reg;
   logic [3:0]       sv_a_reg;
   logic [3:0]       sv_b_reg;
   logic             sv_carry_reg;
   logic             sv_skip_reg;
   logic             sv_nop_reg;
   // Read path
   logic [31:0]      rd_data;
   logic             rd_ok;

   // Write decode; partial strobes are refused
   logic        wr_fire;
   logic        wr_full;
   logic        wr_mapped;
   logic [9:0]  op;
   assign wr_fire   = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
   assign wr_full   = (s_axi_wstrb == 4'hf);
   assign op        = s_axi_wdata[9:0];
   assign wr_mapped = (s_axi_awaddr == REG_INSTR)   | (s_axi_awaddr == REG_PC)
                    | (s_axi_awaddr == REG_PTR)     | (s_axi_awaddr == REG_ACC)
                    | (s_axi_awaddr == REG_SAVE)    | (s_axi_awaddr == REG_PUSH)
                    | (s_axi_awaddr == REG_RAMADDR) | (s_axi_awaddr == REG_RAMDATA)
                    | (s_axi_awaddr == REG_TABLE)   | (s_axi_awaddr == REG_CTRL);

   // Per-register write strobes
   logic wr_go;
   logic wsel_instr;
   logic wsel_pc;
   logic wsel_ptr;
   logic wsel_acc;
   logic wsel_save;
   logic wsel_push;
   logic wsel_ramaddr;
   logic wsel_ramdata;
   logic wsel_table;
   logic wsel_ctrl;
   assign wr_go        = wr_fire & wr_full;
   assign wsel_instr   = wr_go & (s_axi_awaddr == REG_INSTR);
   assign wsel_pc      = wr_go & (s_axi_awaddr == REG_PC);
   assign wsel_ptr     = wr_go & (s_axi_awaddr == REG_PTR);
   assign wsel_acc     = wr_go & (s_axi_awaddr == REG_ACC);
   assign wsel_save    = wr_go & (s_axi_awaddr == REG_SAVE);
   assign wsel_push    = wr_go & (s_axi_awaddr == REG_PUSH);
   assign wsel_ramaddr = wr_go & (s_axi_awaddr == REG_RAMADDR);
   assign wsel_ramdata = wr_go & (s_axi_awaddr == REG_RAMDATA);
   assign wsel_table   = wr_go & (s_axi_awaddr == REG_TABLE);
   assign wsel_ctrl    = wr_go & (s_axi_awaddr == REG_CTRL);

   // Instruction decode; a pending skip swallows one instruction
   logic       exec;
   logic       do_iret;
   logic       do_rts;
   logic       do_pop;
   logic       do_clr;
   logic       do_bset;
   logic [6:0] ptr_addr;
   assign exec     = wsel_instr & ~skip_reg;
   assign do_iret  = exec & (op == OP_INTERRUPT_RETURN);
   assign do_rts   = exec & (op == OP_RETURN_SKIP);
   assign do_pop   = do_iret | do_rts;
   assign do_clr   = exec & (op == OP_TABLE_HIGH_CLEAR);
   assign do_bset  = exec & ((op & OP_BIT_SET_MASK) == OP_BIT_SET_BASE);
   assign ptr_addr = {x_reg[2:0], y_reg};   // Z selects no RAM bank here

   // Write address and data taken together, only while idle
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else if (s_axi_awready) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
                   && state_reg == RBS_IDLE) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end
   end

   // Write response
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wr_full && wr_mapped) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read mux of the register map
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_ok   = 1'b1;
      case (s_axi_araddr)
         REG_INSTR:   rd_data[9:0] = instr_reg;
         REG_STATUS: begin
            rd_data[ST_BUSY_BIT]       = busy_reg;
            rd_data[ST_SKIP_BIT]       = skip_reg;
            rd_data[ST_FLAG_BIT]       = table_high_bits_enable_flag_reg;
            rd_data[ST_SP_LSB +: SP_W] = sp_reg;
            rd_data[ST_HI_LSB +: 2]    = table_high_reg;
         end
         REG_PC:      rd_data[PC_W-1:0] = pc_reg;
         REG_PTR:     rd_data[9:0] = {z_reg, x_reg, y_reg};
         REG_ACC:     rd_data[9:0] = {nop_reg, carry_reg, b_reg, a_reg};
         REG_SAVE:    rd_data[23:0] = {sv_b_reg, sv_a_reg, 1'b0, sv_nop_reg, sv_skip_reg,
                                       sv_carry_reg, 2'h0, sv_z_reg, sv_x_reg, sv_y_reg};
         REG_PUSH:    rd_data[PC_W-1:0] = call_stack[sp_reg];
         REG_RAMADDR: rd_data[6:0] = ram_addr_reg;
         REG_RAMDATA: rd_data[3:0] = ram[ram_addr_reg];
         REG_CTRL:    rd_data[CTRL_SET_BIT] = table_high_bits_enable_flag_reg;
         default:     rd_ok = 1'b0;
      endcase
   end

   // Read address and data channels
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Two-cycle return sequence
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg   <= RBS_IDLE;
         busy_reg    <= 1'b0;
         pop_iret_reg <= 1'b0;
      end else begin
         case (state_reg)
            RBS_IDLE: begin
               if (do_pop) begin
                  state_reg   <= RBS_POP;
                  busy_reg    <= 1'b1;
                  pop_iret_reg <= do_iret;
               end
            end
            RBS_POP: begin
               state_reg <= RBS_IDLE;
               busy_reg  <= 1'b0;
            end
            default: begin
               state_reg <= RBS_IDLE;
               busy_reg  <= 1'b0;
            end
         endcase
      end
   end

   // Program counter loads from the stack top
   always_ff @(posedge mclk) begin
      if (rst) begin
         pc_reg <= PC_RST;
      end else if (do_pop) begin
         pc_reg <= call_stack[sp_reg];
      end else if (wsel_pc) begin
         pc_reg <= s_axi_wdata[PC_W-1:0];
      end
   end

   // Stack pointer falls in the second return cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         sp_reg <= SP_RST;
      end else if (state_reg == RBS_POP) begin
         sp_reg <= sp_reg - SP_ONE;
      end else if (wsel_push) begin
         sp_reg <= sp_reg + SP_ONE;
      end
   end

   // Call stack entries, filled by software pushes
   always_ff @(posedge mclk) begin
      if (wsel_push) begin
         call_stack[sp_reg + SP_ONE] <= s_axi_wdata[PC_W-1:0];
      end
   end

   // Live context: restore, skip, table reference, software writes
   always_ff @(posedge mclk) begin
      if (rst) begin
         {x_reg, y_reg, z_reg, a_reg, b_reg} <= 18'h00000;
         {carry_reg, skip_reg, nop_reg}      <= 3'h0;
      end else if (state_reg == RBS_POP && pop_iret_reg) begin
         x_reg     <= sv_x_reg;
         y_reg     <= sv_y_reg;
         z_reg     <= sv_z_reg;
         a_reg     <= sv_a_reg;
         b_reg     <= sv_b_reg;
         carry_reg <= sv_carry_reg;
         skip_reg  <= sv_skip_reg;
         nop_reg   <= sv_nop_reg;
      end else if (state_reg == RBS_POP) begin
         skip_reg <= 1'b1;
      end else if (wsel_instr && skip_reg) begin
         skip_reg <= 1'b0;
      end else if (wsel_ptr) begin
         y_reg <= s_axi_wdata[PTR_Y_LSB +: 4];
         x_reg <= s_axi_wdata[PTR_X_LSB +: 4];
         z_reg <= s_axi_wdata[PTR_Z_LSB +: 2];
      end else if (wsel_acc) begin
         a_reg     <= s_axi_wdata[ACC_A_LSB +: 4];
         b_reg     <= s_axi_wdata[ACC_B_LSB +: 4];
         carry_reg <= s_axi_wdata[ACC_CY_BIT];
         nop_reg   <= s_axi_wdata[ACC_NOP_BIT];
      end else if (wsel_table) begin
         a_reg <= s_axi_wdata[3:0];
         b_reg <= s_axi_wdata[7:4];
      end
   end

   // Saved context, written by interrupt entry software
   always_ff @(posedge mclk) begin
      if (rst) begin
         {sv_x_reg, sv_y_reg, sv_z_reg, sv_a_reg, sv_b_reg} <= 18'h00000;
         {sv_carry_reg, sv_skip_reg, sv_nop_reg}            <= 3'h0;
      end else if (wsel_save) begin
         sv_y_reg     <= s_axi_wdata[PTR_Y_LSB +: 4];
         sv_x_reg     <= s_axi_wdata[PTR_X_LSB +: 4];
         sv_z_reg     <= s_axi_wdata[PTR_Z_LSB +: 2];
         sv_carry_reg <= s_axi_wdata[SV_CY_BIT];
         sv_skip_reg  <= s_axi_wdata[SV_SKIP_BIT];
         sv_nop_reg   <= s_axi_wdata[SV_NOP_BIT];
         sv_a_reg     <= s_axi_wdata[SV_A_LSB +: 4];
         sv_b_reg     <= s_axi_wdata[SV_B_LSB +: 4];
      end
   end

   // High-bit enable flag: clear op wins over a set
   always_ff @(posedge mclk) begin
      if (rst) begin
         table_high_bits_enable_flag_reg <= FLAG_RST;
      end else if (do_clr) begin
         table_high_bits_enable_flag_reg <= 1'b0;
      end else if (wsel_ctrl && s_axi_wdata[CTRL_SET_BIT]) begin
         table_high_bits_enable_flag_reg <= 1'b1;
      end
   end

   // Upper table bits move only while the flag is set
   always_ff @(posedge mclk) begin
      if (rst) begin
         table_high_reg <= 2'h0;
      end else if (wsel_table && table_high_bits_enable_flag_reg) begin
         table_high_reg <= s_axi_wdata[TAB_HI_LSB +: 2];
      end
   end

   // Data memory: software word writes and single bit sets
   always_ff @(posedge mclk) begin
      if (wsel_ramdata) begin
         ram[ram_addr_reg] <= s_axi_wdata[3:0];
      end else if (do_bset) begin
         ram[ptr_addr][op[1:0]] <= 1'b1;
      end
   end

   // Memory window address and last instruction
   always_ff @(posedge mclk) begin
      if (rst) begin
         ram_addr_reg <= 7'h00;
         instr_reg    <= 10'h000;
      end else begin
         if (wsel_ramaddr) ram_addr_reg <= s_axi_wdata[6:0];
         if (wsel_instr) instr_reg <= op;
      end
   end

   // Checks: helper capture of the bit-set target
   logic [6:0]      bset_a_q;
   logic [1:0]      bset_j_q;
   logic [PC_W-1:0] stack_top;
   assign stack_top = call_stack[sp_reg];
   always_ff @(posedge mclk) begin
      bset_a_q <= ptr_addr;
      bset_j_q <= op[1:0];
   end

   sequence pop_seq;
      do_pop ##1 (state_reg == RBS_POP);
   endsequence

   pc_pop_a: assert property (@(posedge mclk) disable iff (rst)
      do_pop |=> (pc_reg == $past(stack_top)))
      else $error("pc not loaded from stack top");
   sp_dec_a: assert property (@(posedge mclk) disable iff (rst)
      pop_seq |=> (sp_reg == $past(sp_reg, 2) - SP_ONE) && (state_reg == RBS_IDLE))
      else $error("stack pointer not decremented once");
   ctx_restore_a: assert property (@(posedge mclk) disable iff (rst)
      do_iret |=> ##1 (a_reg == $past(sv_a_reg, 2)) && (b_reg == $past(sv_b_reg, 2))
         && (x_reg == $past(sv_x_reg, 2)) && (carry_reg == $past(sv_carry_reg, 2))
         && (nop_reg == $past(sv_nop_reg, 2)))
      else $error("context not restored");
   ret_skip_a: assert property (@(posedge mclk) disable iff (rst)
      do_rts |-> !skip_reg ##2 skip_reg)
      else $error("return skip not armed");
   flag_clr_a: assert property (@(posedge mclk) disable iff (rst)
      do_clr |=> !table_high_bits_enable_flag_reg)
      else $error("enable flag not cleared");
   tab_hold_a: assert property (@(posedge mclk) disable iff (rst)
      (wsel_table && !table_high_bits_enable_flag_reg) |=> $stable(table_high_reg))
      else $error("high bits moved with flag clear");
   bit_set_a: assert property (@(posedge mclk) disable iff (rst)
      do_bset |=> ram[bset_a_q][bset_j_q])
      else $error("memory bit not set");
endmodule // rbs_exec_unit
`default_nettype wire

// >>> tb.sv
// Self-checking bench of the return and bit-set execution unit
// Assumes rbs_pkg and rbs_exec_unit are compiled before this file
`timescale 1ns/100ps
`default_nettype none
module tb;
   import rbs_pkg::*;
   logic              mclk;
   logic              rst;
   logic [7:0]        awaddr;
   logic [7:0]        araddr;
   logic [2:0]        awprot;
   logic [2:0]        arprot;
   logic              awvalid;
   logic              wvalid;
   logic              bready;
   logic              arvalid;
   logic              rready;
   logic [31:0]       wdata;
   logic [3:0]        wstrb;
   wire logic         awready;
   wire logic         wready;
   wire logic         bvalid;
   wire logic         arready;
   wire logic         rvalid;
   wire logic         busy;
   wire logic [1:0]   bresp;
   wire logic [1:0]   rresp;
   wire logic [1:0]   thigh;
   wire logic [31:0]  rdata;
   int                mismatches;
   int                checked;
   int                busy_cnt;
   logic [31:0]       save;
   logic [31:0]       ptr;
   logic [31:0]       acc;
   logic [1:0]        rs;
   logic [13:0]       v0;
   logic [13:0]       v1;
   logic [2:0]        sp_m;
   logic              flag_m;
   logic              skip_m;
   logic [1:0]        th_m;

   // Unit under test
   rbs_exec_unit dut (.mclk(mclk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awprot(awprot), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(arprot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .busy_reg(busy), .table_high_reg(thigh));

   // Clock, 8 ns period
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   // Counts cycles spent in the second step of a return
   always @(posedge mclk) begin
      if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Status word as the unit should report it
   function automatic logic [31:0] exp_status();
      return {18'h0, th_m, 1'b0, sp_m, 5'h0, flag_m, skip_m, 1'b0};
   endfunction

   // One write: address and data offered together, held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      int n;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      r = 2'h1;
      for (n = 0; n < 200; n++) begin
         @(posedge mclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
      if (n == 200) mismatches++;
   endtask

   // One read, held until the answer is sampled
   task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      d = 32'h0;
      r = 2'h1;
      for (n = 0; n < 200; n++) begin
         @(posedge mclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
      if (n == 200) mismatches++;
   endtask

   task automatic wok(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, 4'hf, r);
      check(32'(r), 32'(RESP_OKAY));
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      rdr(a, d, r);
      check(32'(r), 32'(RESP_OKAY));
      check(d, exp);
   endtask

   task automatic push(input logic [13:0] v);
      wok(REG_PUSH, 32'(v));
      sp_m = sp_m + SP_ONE;
      rchk(REG_PUSH, 32'(v));
   endtask

   // Bit 0 set op on the word under the pointer; hit says whether it may act
   task automatic probe(input logic hit);
      wok(REG_RAMADDR, {25'h0, ptr[6:0]});
      wok(REG_RAMDATA, 32'h0);
      wok(REG_INSTR, 32'(OP_BIT_SET_BASE));
      rchk(REG_RAMDATA, {31'h0, hit});
   endtask

   // A return: pop, one extra busy cycle, then the skipped instruction
   task automatic ret(input logic [9:0] op, input logic [13:0] pc);
      int n;
      n = busy_cnt;
      wok(REG_INSTR, 32'(op));
      sp_m = sp_m - SP_ONE;
      skip_m = 1'b1;
      rchk(REG_PC, 32'(pc));
      check(32'(busy_cnt - n), 32'h1);
      rchk(REG_STATUS, exp_status());
      probe(1'b0);
      skip_m = 1'b0;
      probe(1'b1);
      rchk(REG_STATUS, exp_status());
   endtask

   // Watchdog, far beyond the expected run
   initial begin
      #(8 * 20000);
      mismatches++;
      stop_test();
   end

   initial begin
      rst = 1'b1;
      {awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      mismatches = 0;
      checked = 0;
      busy_cnt = 0;
      void'($urandom(72));
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      sp_m = SP_RST;
      flag_m = FLAG_RST;
      skip_m = 1'b0;
      th_m = 2'h0;
      rchk(REG_STATUS, exp_status());
      rchk(REG_PC, 32'h0);
      // Every bit position, random pointer and prior contents
      for (int j = 0; j < 4; j++) begin
         ptr = $urandom() & 32'h3ff;
         acc = $urandom() & 32'hf;
         wok(REG_PTR, ptr);
         wok(REG_RAMADDR, {25'h0, ptr[6:0]});
         wok(REG_RAMDATA, acc);
         wok(REG_INSTR, 32'(OP_BIT_SET_BASE) + j);
         rchk(REG_RAMDATA, acc | (32'h1 << j));
      end
      // Interrupt return from two deep, first push wraps the pointer from 7 to 0
      v0 = 14'($urandom());
      v1 = 14'($urandom());
      push(v0);
      push(v1);
      save = ($urandom() & 32'h00ff_73ff) | 32'h0000_2000;
      wok(REG_SAVE, save);
      wok(REG_ACC, 32'h0);
      wok(REG_PTR, 32'h0);
      ptr = save & 32'h3ff;
      ret(OP_INTERRUPT_RETURN, v1);
      rchk(REG_PTR, ptr);
      rchk(REG_ACC, {22'h0, save[14], save[12], save[23:16]});
      // Return with unconditional skip
      push(v0);
      ret(OP_RETURN_SKIP, v0);
      // Table reference with the flag set, then cleared
      wok(REG_CTRL, 32'h1);
      flag_m = 1'b1;
      acc = ($urandom() & 32'hff) | 32'h200;
      wok(REG_TABLE, acc);
      th_m = 2'h2;
      check(32'(thigh), 32'(th_m));
      wok(REG_INSTR, 32'(OP_TABLE_HIGH_CLEAR));
      flag_m = 1'b0;
      rchk(REG_STATUS, exp_status());
      rchk(REG_CTRL, 32'h0);
      wok(REG_TABLE, acc ^ 32'h300);
      check(32'(thigh), 32'(th_m));
      rchk(REG_STATUS, exp_status());
      // Refused accesses
      wr(8'hfc, 32'h1, 4'hf, rs);
      check(32'(rs), 32'(RESP_SLVERR));
      wr(REG_PC, 32'h3, 4'h3, rs);
      check(32'(rs), 32'(RESP_SLVERR));
      wr(REG_STATUS, 32'h7, 4'hf, rs);
      check(32'(rs), 32'(RESP_SLVERR));
      rdr(8'hfc, acc, rs);
      check(32'(rs), 32'(RESP_SLVERR));
      check(acc, 32'h0);
      rdr(REG_TABLE, acc, rs);
      check(32'(rs), 32'(RESP_SLVERR));
      rchk(REG_PC, 32'(v0));
      // A full-word program counter write lands
      wok(REG_PC, 32'(v1));
      rchk(REG_PC, 32'(v1));
      rchk(REG_STATUS, exp_status());
      stop_test();
   end
endmodule // tb
`default_nettype wire
